/* File: logic/i2cst_pkg.sv */
// Package with register map, field positions, status codes and carrier types.
package i2cst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the plain register port.
  localparam logic [2:0] REG_OWN_SLAVE_ADDRESS = 3'h0;
  localparam logic [2:0] REG_INTERFACE_CONTROL = 3'h1;
  localparam logic [2:0] REG_BUS_STATUS_CODE   = 3'h2;
  localparam logic [2:0] REG_BUS_DATA_BYTE     = 3'h3;
  localparam logic [2:0] REG_EVENT_STATUS      = 3'h4;
  localparam logic [2:0] REG_EVENT_MASK        = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in interface_control and own_slave_address.
  localparam int CTL_INTERRUPT_FLAG   = 7;
  localparam int CTL_ACK_ENABLE       = 6;
  localparam int CTL_START_REQUEST    = 5;
  localparam int CTL_STOP_REQUEST     = 4;
  localparam int CTL_INTERFACE_ENABLE = 2;
  localparam int ADR_GENERAL_CALL_EN  = 0;

  // Event bits in the sticky event status and mask registers.
  localparam int EVT_ADDRESSED = 0;
  localparam int EVT_BYTE_ACKED = 1;
  localparam int EVT_TRANSFER_END = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] RST_OWN_ADDRESS = 8'h00;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_DATA        = 8'hFF;
  localparam logic [7:0] RST_EVENTS      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Status codes; the three low bits always read as zero.
  localparam logic [7:0] STS_OWN_READ      = 8'hA8;
  localparam logic [7:0] STS_ARB_LOST_READ = 8'hB0;
  localparam logic [7:0] STS_BYTE_ACKED    = 8'hB8;
  localparam logic [7:0] STS_BYTE_NACKED   = 8'hC0;
  localparam logic [7:0] STS_LAST_ACKED    = 8'hC8;
  localparam logic [7:0] STS_NO_INFO       = 8'hF8;

  // Bit counts in a byte on the bus.
  localparam logic [3:0] CNT_ADDR_BITS = 4'h8;
  localparam logic [3:0] CNT_LAST_BIT  = 4'h7;
  localparam logic [6:0] GENERAL_CALL_ADDRESS = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register port request carrier.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } i2cst_req_s;

  // Protocol states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_LOAD   = 3'b011,
    ST_TX     = 3'b100,
    ST_RACK   = 3'b101,
    ST_IGNORE = 3'b110
  } i2cst_state_e;

endpackage

/* File: logic/i2cst_slave_tx.sv */
// Slave-transmitter engine of the two-wire interface with its register file.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module i2cst_slave_tx (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Register port.
  input  wire i2cst_pkg::i2cst_req_s reg_req,
  output logic [7:0]               reg_rdata,
  // Bus clock pin.
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe_n,
  // Bus data pin.
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  // Neighbouring unit logic.
  input  wire logic                master_arb_lost,
  input  wire logic                sleep_active,
  output logic                     wake_req,
  output logic                     start_on_free,
  output logic                     irq
);
  import i2cst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0]   own_slave_address;
  logic [7:0]   interface_control;
  logic [7:0]   bus_status_code;
  logic [7:0]   bus_data_byte;
  logic [7:0]   event_status;
  logic [7:0]   event_mask;
  logic         scl_meta;
  logic         scl_sync;
  logic         scl_prev;
  logic         sda_meta;
  logic         sda_sync;
  logic         sda_prev;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         bus_free;
  i2cst_state_e st;
  logic [3:0]   bitcnt;
  logic [7:0]   shreg;
  logic         sda_drv;
  logic         scl_drv;
  logic         last_byte;
  logic         got_ack;
  logic         arb_hit;
  logic         interrupt_flag;
  logic         acknowledge_enable;
  logic         interface_enable;
  logic         addr_match;
  logic         ev_addressed;
  logic         ev_byte_acked;
  logic         ev_byte_nacked;
  logic         ev_last_acked;
  logic         flag_clear;
  logic [7:0]   next_events;

  assign interrupt_flag     = interface_control[CTL_INTERRUPT_FLAG];
  assign acknowledge_enable = interface_control[CTL_ACK_ENABLE];
  assign interface_enable   = interface_control[CTL_INTERFACE_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Two-flip-flop synchronisers for both bus pins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  // Previous synchronised levels for edge detection.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  // Bus edges and START and STOP conditions.
  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // Bus busy tracking; a queued START waits for this.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_free <= 1'b1;
    end else if (start_det) begin
      bus_free <= 1'b0;
    end else if (stop_det) begin
      bus_free <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address match: own address, or general call when enabled, only while acking.
  assign addr_match = interface_enable & acknowledge_enable &
                      ((shreg[7:1] == own_slave_address[7:1]) |
                       ((shreg[7:1] == GENERAL_CALL_ADDRESS) &
                        own_slave_address[ADR_GENERAL_CALL_EN]));

  // Protocol events that set the flag and status code.
  assign ev_addressed   = (st == ST_ACK) & scl_fall;
  assign ev_byte_acked  = (st == ST_RACK) & scl_fall & got_ack & ~last_byte;
  assign ev_byte_nacked = (st == ST_RACK) & scl_fall & ~got_ack;
  assign ev_last_acked  = (st == ST_RACK) & scl_fall & got_ack & last_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine: address, acknowledge, byte transmit, master ACK.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st        <= ST_IDLE;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      sda_drv   <= 1'b0;
      last_byte <= 1'b0;
      got_ack   <= 1'b0;
      arb_hit   <= 1'b0;
    end else if (!interface_enable) begin
      st      <= ST_IDLE;
      sda_drv <= 1'b0;
    end else if (stop_det) begin
      st      <= ST_IDLE;
      sda_drv <= 1'b0;
    end else if (start_det) begin
      st      <= ST_ADDR;
      bitcnt  <= 4'h0;
      sda_drv <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          sda_drv <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_sync};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == CNT_ADDR_BITS) begin
            // Direction one means a read: enter transmit and pull SDA for ACK.
            if (addr_match && shreg[0]) begin
              st      <= ST_ACK;
              sda_drv <= 1'b1;
              arb_hit <= master_arb_lost;
            end else begin
              st <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_drv <= 1'b0;
            st      <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Next byte goes out once software has cleared the flag.
          if (!interrupt_flag) begin
            shreg     <= bus_data_byte;
            last_byte <= ~acknowledge_enable;
            bitcnt    <= 4'h0;
            sda_drv   <= ~bus_data_byte[7];
            st        <= ST_TX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == CNT_LAST_BIT) begin
              sda_drv <= 1'b0;
              st      <= ST_RACK;
            end else begin
              shreg   <= {shreg[6:0], 1'b1};
              sda_drv <= ~shreg[6];
              bitcnt  <= bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            got_ack <= ~sda_sync;
          end else if (scl_fall) begin
            // After a last byte or a NACK the slave is no longer addressed.
            if (last_byte || !got_ack) begin
              st <= ST_IGNORE;
            end else begin
              st <= ST_LOAD;
            end
          end
        end
        ST_IGNORE: begin
          sda_drv <= 1'b0;
        end
        default: begin
          st      <= ST_IDLE;
          sda_drv <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock stretching while the flag is pending in an addressed transfer.
  // SCL is held for the whole load state, so the first data bit is on SDA
  // one cycle before the clock is let go and the master never sees a setup race.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_drv <= 1'b0;
    end else begin
      scl_drv <= (st == ST_LOAD) | ev_addressed |
                 ev_byte_acked;
    end
  end

  // Open-drain pins: output low, enable low while pulling.
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = ~scl_drv;
  assign sda_oe_n = ~sda_drv;

  ////////////////////////////////////////////////////////////////////////////
  // Control register: flag set by hardware wins over a write-one clear.
  assign flag_clear = reg_req.wr & (reg_req.addr == REG_INTERFACE_CONTROL) &
                      reg_req.wdata[CTL_INTERRUPT_FLAG];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interface_control <= RST_CONTROL;
    end else begin
      if (reg_req.wr && reg_req.addr == REG_INTERFACE_CONTROL) begin
        interface_control[CTL_ACK_ENABLE]       <= reg_req.wdata[CTL_ACK_ENABLE];
        interface_control[CTL_START_REQUEST]    <= reg_req.wdata[CTL_START_REQUEST];
        interface_control[CTL_STOP_REQUEST]     <= reg_req.wdata[CTL_STOP_REQUEST];
        interface_control[CTL_INTERFACE_ENABLE] <= reg_req.wdata[CTL_INTERFACE_ENABLE];
      end
      if (ev_addressed || ev_byte_acked || ev_byte_nacked || ev_last_acked) begin
        interface_control[CTL_INTERRUPT_FLAG] <= 1'b1;
      end else if (flag_clear) begin
        interface_control[CTL_INTERRUPT_FLAG] <= 1'b0;
      end
    end
  end

  // Status code register; low three bits stay zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_status_code <= STS_NO_INFO;
    end else if (ev_addressed) begin
      bus_status_code <= arb_hit ? STS_ARB_LOST_READ : STS_OWN_READ;
    end else if (ev_byte_acked) begin
      bus_status_code <= STS_BYTE_ACKED;
    end else if (ev_byte_nacked) begin
      bus_status_code <= STS_BYTE_NACKED;
    end else if (ev_last_acked) begin
      bus_status_code <= STS_LAST_ACKED;
    end else if (flag_clear && !interrupt_flag) begin
      bus_status_code <= STS_NO_INFO;
    end
  end

  // Address and data registers; the data byte only changes by software.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      own_slave_address <= RST_OWN_ADDRESS;
      bus_data_byte     <= RST_DATA;
    end else if (reg_req.wr) begin
      if (reg_req.addr == REG_OWN_SLAVE_ADDRESS) begin
        own_slave_address <= reg_req.wdata;
      end
      if (reg_req.addr == REG_BUS_DATA_BYTE) begin
        bus_data_byte <= reg_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event bits, write one to clear, set wins; mask register.
  always_comb begin
    next_events = event_status;
    if (reg_req.wr && reg_req.addr == REG_EVENT_STATUS) begin
      next_events = event_status & ~reg_req.wdata;
    end
    if (ev_addressed) begin
      next_events[EVT_ADDRESSED] = 1'b1;
    end
    if (ev_byte_acked) begin
      next_events[EVT_BYTE_ACKED] = 1'b1;
    end
    if (ev_byte_nacked || ev_last_acked) begin
      next_events[EVT_TRANSFER_END] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_status <= RST_EVENTS;
      event_mask   <= RST_EVENTS;
    end else begin
      event_status <= next_events & 8'h07;
      if (reg_req.wr && reg_req.addr == REG_EVENT_MASK) begin
        event_mask <= reg_req.wdata & 8'h07;
      end
    end
  end

  // Level interrupt output.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_events & event_mask & 8'h07);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake request while asleep and addressed, until the flag is cleared.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else if (ev_addressed && sleep_active) begin
      wake_req <= 1'b1;
    end else if (!interrupt_flag) begin
      wake_req <= 1'b0;
    end
  end

  // Queued START once the bus is free and the slave is not addressed.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_on_free <= 1'b0;
    end else begin
      start_on_free <= interface_control[CTL_START_REQUEST] & bus_free &
                       ((st == ST_IDLE) | (st == ST_IGNORE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data, one cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        REG_OWN_SLAVE_ADDRESS: reg_rdata <= own_slave_address;
        REG_INTERFACE_CONTROL: reg_rdata <= interface_control;
        REG_BUS_STATUS_CODE:   reg_rdata <= bus_status_code;
        REG_BUS_DATA_BYTE:     reg_rdata <= bus_data_byte;
        REG_EVENT_STATUS:      reg_rdata <= event_status;
        REG_EVENT_MASK:        reg_rdata <= event_mask;
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  status_low_zero_a: assert property (bus_status_code[2:0] == 3'b000)
    else $error("status code low bits not zero");

  own_read_code_a: assert property (
    ev_addressed && !arb_hit |=> interrupt_flag && bus_status_code == STS_OWN_READ)
    else $error("own read address did not give A8 with flag");

  arb_read_code_a: assert property (
    ev_addressed && arb_hit |=> bus_status_code == STS_ARB_LOST_READ)
    else $error("arbitration lost read did not give B0");

  no_ack_disabled_a: assert property (
    st == ST_ADDR && scl_fall && bitcnt == CNT_ADDR_BITS && !acknowledge_enable
    && !stop_det && !start_det |=> st == ST_IGNORE && sda_oe_n)
    else $error("address acknowledged with acknowledge enable low");

  gc_disabled_a: assert property (
    st == ST_ADDR && scl_fall && bitcnt == CNT_ADDR_BITS && shreg[7:1] == 7'h00
    && own_slave_address[7:1] != 7'h00 && !own_slave_address[0] |=> st != ST_ACK)
    else $error("general call answered while disabled");

  byte_acked_code_a: assert property (
    ev_byte_acked && !flag_clear |=> bus_status_code == STS_BYTE_ACKED ##1 interrupt_flag)
    else $error("acked byte did not give B8");

  last_byte_end_a: assert property (
    ev_last_acked |=> bus_status_code == STS_LAST_ACKED && st == ST_IGNORE)
    else $error("last byte with ACK did not give C8 and release");

  ignore_released_a: assert property (
    st == ST_IGNORE |=> sda_oe_n || start_det || stop_det || $past(start_det))
    else $error("SDA driven while not addressed");

  stretch_hold_a: assert property (
    st == ST_LOAD && interrupt_flag && $past(st == ST_LOAD && interrupt_flag)
    |-> !scl_oe_n)
    else $error("SCL not held while flag pending");

  wake_level_a: assert property (
    ev_addressed && sleep_active |=> wake_req [*2])
    else $error("wake request not raised in sleep");

endmodule // i2cst_slave_tx

/* File: verification/i2cst_bus_master.sv */
// Behavioural two-wire bus master that reads bytes from the device.
`timescale 1ns/1ps
module i2cst_bus_master (
  // Wired bus levels.
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Open-drain drives; a one releases the line to its pull-up.
  output logic      scl_d,
  output logic      sda_d,
  // Raised when the device holds the clock low for too long.
  output logic      hang
);
  // Both lines start released.
  initial begin
    scl_d = 1'b1;
    sda_d = 1'b1;
    hang  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release SCL and wait out any stretch under a bound.
  task automatic rise();
    int n;
    n = 0;
    scl_d = 1'b1;
    while (scl_w !== 1'b1 && n < 5000) begin
      #20;
      n++;
    end
    if (n == 5000) hang = 1'b1;
    #40;
  endtask

  // One bit: drive in the low half, sample in the high half.
  task automatic bit_io(input logic b, output logic s);
    #40 sda_d = b;
    #40 rise();
    s = sda_w;
    #40 scl_d = 1'b0;
  endtask

  // Start condition from an idle bus.
  task automatic start();
    #40 sda_d = 1'b0;
    #80 scl_d = 1'b0;
  endtask

  // Stop condition; leaves both lines released.
  task automatic stop();
    #40 sda_d = 1'b0;
    #40 rise();
    #40 sda_d = 1'b1;
    #80;
  endtask

  // Address byte out, acknowledge in; ack is one when SDA was pulled low.
  task automatic send(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Data byte in, then the master's own ACK or NACK.
  task automatic recv(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(~ack, s);
  endtask
endmodule // i2cst_bus_master

/* File: verification/tb.sv */
// Self-checking bench for the slave-transmitter engine.
`timescale 1ns/1ps
module tb;
  import i2cst_pkg::*;
  logic       sys_clk, rst, scl_out, sda_out, scl_oe_n, sda_oe_n;
  logic       master_arb_lost, sleep_active, wake_req, start_on_free, irq;
  logic       m_scl, m_sda, hang, scl_w, sda_w;
  i2cst_req_s reg_req;
  logic [7:0] reg_rdata, got;
  logic [6:0] own;
  logic [31:0] seed;
  int         err_count, check_count;

  // Wired-AND of both parties on each open-drain line.
  assign scl_w = m_scl & (scl_oe_n | scl_out);
  assign sda_w = m_sda & (sda_oe_n | sda_out);

  i2cst_slave_tx u_i2cst_slave_tx (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .master_arb_lost(master_arb_lost), .sleep_active(sleep_active),
    .wake_req(wake_req), .start_on_free(start_on_free), .irq(irq));

  i2cst_bus_master u_master (.scl_w(scl_w), .sda_w(sda_w), .scl_d(m_scl),
    .sda_d(m_sda), .hang(hang));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got_v, input logic [7:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic chk1(input logic got_v, input logic exp_v);
    chk8({7'h00, got_v}, {7'h00, exp_v});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles, one strobe cycle each.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp_v);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp_v);
  endtask

  // Poll the flag under a bound; running out ends the run.
  task automatic wait_flag();
    logic [7:0] d;
    for (int n = 0; n < 64; n++) begin
      rd(REG_INTERFACE_CONTROL, d);
      if (d[CTL_INTERRUPT_FLAG] === 1'b1) return;
    end
    err_count++;
    wrap_up();
  endtask

  // Start, address byte, compare the acknowledge.
  task automatic addr_phase(input logic [7:0] w, input logic exp_ack);
    logic a;
    u_master.start();
    u_master.send(w, a);
    chk1(a, exp_ack);
  endtask

  // Load a random byte, clear the flag, let the master fetch it.
  task automatic xfer(input logic ae, input logic mack, input logic [7:0] sts);
    logic [7:0] v, b;
    v = 8'(rnd());
    wr(REG_BUS_DATA_BYTE, v);
    wr(REG_INTERFACE_CONTROL, {1'b1, ae, 6'b00_0100});
    u_master.recv(mack, b);
    chk8(b, v);
    wait_flag();
    rd_chk(REG_BUS_STATUS_CODE, sts);
  endtask

  // A clock held low too long by the device ends the run.
  always @(posedge hang) begin
    err_count++;
    wrap_up();
  end

  // Overall limit on the run.
  initial begin
    #1000000;
    err_count++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 32'hcbeb_ca65;
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    reg_req = '0;
    master_arb_lost = 1'b0;
    sleep_active = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(REG_BUS_STATUS_CODE, STS_NO_INFO);
    rd_chk(REG_BUS_DATA_BYTE, RST_DATA);
    rd_chk(REG_INTERFACE_CONTROL, RST_CONTROL);
    rd_chk(3'h7, 8'h00);
    own = 7'(rnd()) | 7'h10;
    wr(REG_OWN_SLAVE_ADDRESS, {own, 1'b0});
    rd_chk(REG_OWN_SLAVE_ADDRESS, {own, 1'b0});
    wr(REG_EVENT_MASK, 8'h07);
    wr(REG_INTERFACE_CONTROL, 8'h04);
    addr_phase({own, 1'b1}, 1'b0);
    u_master.stop();
    wr(REG_INTERFACE_CONTROL, 8'h44);
    addr_phase({own ^ 7'h01, 1'b1}, 1'b0);
    u_master.stop();
    addr_phase({own, 1'b0}, 1'b0);
    u_master.stop();
    addr_phase({GENERAL_CALL_ADDRESS, 1'b1}, 1'b0);
    u_master.stop();
    // Plain read: several acked bytes, then a last one the master still acks.
    addr_phase({own, 1'b1}, 1'b1);
    wait_flag();
    rd_chk(REG_BUS_STATUS_CODE, STS_OWN_READ);
    chk1(scl_oe_n, 1'b0);
    chk1(irq, 1'b1);
    rd_chk(REG_EVENT_STATUS, 8'h01);
    wr(REG_EVENT_STATUS, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk1(irq, 1'b0);
    for (int k = 0; k < 3; k++) xfer(1'b1, 1'b1, STS_BYTE_ACKED);
    xfer(1'b0, 1'b1, STS_LAST_ACKED);
    u_master.recv(1'b1, got);
    chk8(got, 8'hFF);
    u_master.stop();
    rd_chk(REG_EVENT_STATUS, 8'h06);
    wr(REG_EVENT_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk1(irq, 1'b0);
    wr(REG_EVENT_STATUS, 8'h06);
    wr(REG_INTERFACE_CONTROL, 8'hC4);
    // General call after lost arbitration, ended by the master's NACK.
    wr(REG_OWN_SLAVE_ADDRESS, {own, 1'b1});
    @(posedge sys_clk);
    master_arb_lost <= 1'b1;
    addr_phase({GENERAL_CALL_ADDRESS, 1'b1}, 1'b1);
    wait_flag();
    rd_chk(REG_BUS_STATUS_CODE, STS_ARB_LOST_READ);
    master_arb_lost <= 1'b0;
    xfer(1'b0, 1'b0, STS_BYTE_NACKED);
    u_master.stop();
    wr(REG_INTERFACE_CONTROL, 8'hC4);
    // Addressed while asleep: wake request until the flag is cleared.
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    addr_phase({own, 1'b1}, 1'b1);
    wait_flag();
    chk1(wake_req, 1'b1);
    chk1(scl_oe_n, 1'b0);
    xfer(1'b0, 1'b0, STS_BYTE_NACKED);
    chk1(wake_req, 1'b0);
    sleep_active <= 1'b0;
    u_master.stop();
    // Start request queued on a free bus.
    wr(REG_INTERFACE_CONTROL, 8'hE4);
    repeat (3) @(posedge sys_clk);
    #1 chk1(start_on_free, 1'b1);
    wr(REG_INTERFACE_CONTROL, 8'h44);
    repeat (3) @(posedge sys_clk);
    #1 chk1(start_on_free, 1'b0);
    wrap_up();
  end
endmodule // tb
